// File: sciem_ev_if.sv
// Interface carrying raw flags and enables between event core and top.
// Assumes both ends share sys_clk_in.
`timescale 1ns/1ps
interface sciem_ev_if;
  import sciem_pkg::*;
  sciem_ev_t raw_event_status;        // Raw flags, hardware owned
  sciem_ev_t event_in;                // Synchronised event pulses/levels
  sciem_ev_t clear_req;               // Write-one-to-clear requests
  sciem_ev_t sysctl_event_enable;     // Enable mask
  logic irq;                          // Combined request

  modport core (input event_in, input clear_req, input sysctl_event_enable,
                output raw_event_status, output irq);
  modport top (output event_in, output clear_req, output sysctl_event_enable,
               input raw_event_status, input irq);
endinterface

// File: sciem_event_enable.sv
// System-control event enable block: mask register, raw and masked status,
// interrupt request to the processor.
// Assumes classic Wishbone single cycles and synchronous active-high reset.
//
// Function
// - One mask register holds all event enables
// - Brown-out interrupts only when enable bit 1
// - Pll fault interrupts only when enable bit 0
// - Bit 1 read/write, resets to zero
// - Bit 0 read/write, resets to zero
// - Raw flags set by hardware, cleared by write-one to masked status
// - Request is OR of flags AND enables
`timescale 1ns/1ps
module sciem_event_enable
  import sciem_pkg::*;
(
  input wire logic sys_clk_in,                 // System clock, 100 MHz
  input wire logic srst_in,                    // Synchronous reset, active high
  input wire logic [6:0] event_in,             // Event sources, asynchronous
  input wire logic wb_cyc_in,                  // Wishbone cycle
  input wire logic wb_stb_in,                  // Wishbone strobe
  input wire logic wb_we_in,                   // Wishbone write enable
  input wire logic [11:0] wb_adr_in,           // Wishbone byte address
  input wire logic [3:0] wb_sel_in,            // Wishbone byte selects
  input wire logic [31:0] wb_dat_in,           // Wishbone write data
  output logic [31:0] wb_dat_out,              // Wishbone read data
  output logic wb_ack_out,                     // Wishbone acknowledge
  output logic wb_err_out,                     // Wishbone error
  output logic irq_out                         // Interrupt request, level
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  typedef enum {SCIEM_SEL_NONE, SCIEM_SEL_RAW, SCIEM_SEL_EN, SCIEM_SEL_STAT} sciem_sel_t;

  // Decoding used by both read and write paths
  function automatic sciem_sel_t sciem_decode(input logic [11:0] adr);
    sciem_sel_t sel;
    sel = SCIEM_SEL_NONE;
    case (adr)
      SCIEM_RAW_OFFSET: sel = SCIEM_SEL_RAW;
      SCIEM_EN_OFFSET: sel = SCIEM_SEL_EN;
      SCIEM_STAT_OFFSET: sel = SCIEM_SEL_STAT;
      default: sel = SCIEM_SEL_NONE;
    endcase
    return sel;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    sciem_ev_t sync1;                 // First synchroniser stage
    sciem_ev_t sync2;                 // Second synchroniser stage
    sciem_ev_t enable;                // Event enable mask
    logic [31:0] rdata;               // Registered read data
    logic ack;                        // Acknowledge
    logic err;                        // Error for unmapped address
    logic irq;                        // Registered interrupt request
  } sciem_state_t;

  sciem_state_t state_q;              // Registered state
  sciem_state_t state_d;              // Next state
  sciem_ev_if ev();                   // Bundle to the raw flag core
  sciem_sel_t dec;                    // Decoded register
  logic req;                          // New bus request this cycle
  sciem_ev_t masked;                  // Flags gated by enables

  // ----------------------------------------------------------------
  // Raw flag core
  // ----------------------------------------------------------------
  // Flags live in their own module so set/clear priority sits in one place;
  // this module only feeds it synchronised events, clear requests and the enable mask
  sciem_raw_flags u_sciem_raw_flags
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // Bus request
  // ----------------------------------------------------------------
  assign dec = sciem_decode(wb_adr_in);
  // One answer per cycle; the registered ack or err blocks a second take
  assign req = wb_cyc_in && wb_stb_in && !state_q.ack && !state_q.err;
  assign masked = ev.raw_event_status & state_q.enable;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    state_d.sync1 = event_in;
    // Only the second stage feeds the flag logic
    state_d.sync2 = state_q.sync1;
    state_d.ack = 1'b0;
    state_d.err = 1'b0;
    ev.clear_req = '0;
    if (req)
    begin
      if (dec == SCIEM_SEL_NONE)
      begin
        // Unmapped address answers with an error
        state_d.err = 1'b1;
        state_d.rdata = 32'h0000_0000;
      end
      else
      begin
        state_d.ack = 1'b1;
        if (wb_we_in)
        begin
          // Enable mask is the single stored software control; status writes only clear flags
          if (dec == SCIEM_SEL_EN && wb_sel_in[0])
          begin
            state_d.enable = wb_dat_in[6:0];
          end
          // Raw status ignores writes: hardware owned
          else if (dec == SCIEM_SEL_STAT && wb_sel_in[0])
          begin
            ev.clear_req = wb_dat_in[6:0];
          end
        end
        // Reads: bits 31:7 return zero
        case (dec)
          SCIEM_SEL_RAW: state_d.rdata = {25'h0000000, ev.raw_event_status};
          SCIEM_SEL_EN: state_d.rdata = {25'h0000000, state_q.enable};
          SCIEM_SEL_STAT: state_d.rdata = {25'h0000000, masked};
          default: state_d.rdata = 32'h0000_0000;
        endcase
      end
    end
    // Request level from flags gated by enables
    state_d.irq = ev.irq;
  end

  // Register the state
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_q <= '0;
      state_q.enable <= SCIEM_EN_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All bus and request outputs come straight from flops, so the
  // processor never sees a glitch while flags and enables settle
  assign ev.event_in = state_q.sync2;
  assign ev.sysctl_event_enable = state_q.enable;
  assign wb_dat_out = state_q.rdata;
  assign wb_ack_out = state_q.ack;
  assign wb_err_out = state_q.err;
  assign irq_out = state_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // A write to the enable register that sets bit b to v
  sequence s_en_write(int b, logic v);
    req && wb_we_in && dec == SCIEM_SEL_EN && wb_sel_in[0] && wb_dat_in[b] == v;
  endsequence

  // A request to a mapped register taken at this edge
  sequence s_take_mapped;
    req && dec != SCIEM_SEL_NONE;
  endsequence

  // A request to a hole in the map taken at this edge
  sequence s_take_unmapped;
    req && dec == SCIEM_SEL_NONE;
  endsequence

  // A write-one-to-clear of bit b with no fresh event on that bit
  sequence s_clear_bit(int b);
    req && wb_we_in && dec == SCIEM_SEL_STAT && wb_sel_in[0] && wb_dat_in[b] && !ev.event_in[b];
  endsequence

  // A read of register r taken at this edge
  sequence s_read(sciem_sel_t r);
    req && !wb_we_in && dec == r;
  endsequence

  // Ack for one cycle, then quiet while the master lets go
  sequence s_ack_pulse;
    wb_ack_out && !wb_err_out ##1 !wb_ack_out;
  endsequence

  // Err for one cycle, then quiet; no ack alongside it
  sequence s_err_pulse;
    wb_err_out && !wb_ack_out ##1 !wb_err_out;
  endsequence

  // Brown-out and pll fault gating; the request lags its flag by one
  // cycle because the output is a flop, which keeps glitches off the pin

  a_brownout_gated: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!state_q.enable[SCIEM_BROWNOUT_BIT] && ev.raw_event_status == 7'h02) |=> !irq_out)
    else $error("brown-out raised interrupt while disabled");
  a_brownout_raises: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (state_q.enable[SCIEM_BROWNOUT_BIT] && ev.raw_event_status[SCIEM_BROWNOUT_BIT]) |=> irq_out)
    else $error("enabled brown-out did not raise interrupt");
  a_pllfault_gated: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!state_q.enable[SCIEM_PLL_FAULT_BIT] && ev.raw_event_status == 7'h01) |=> !irq_out)
    else $error("pll fault raised interrupt while disabled");
  a_pllfault_raises: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (state_q.enable[SCIEM_PLL_FAULT_BIT] && ev.raw_event_status[SCIEM_PLL_FAULT_BIT]) |=> irq_out)
    else $error("enabled pll fault did not raise interrupt");
  a_brownout_write: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_en_write(SCIEM_BROWNOUT_BIT, 1'b1) |=> wb_ack_out ##1 state_q.enable[SCIEM_BROWNOUT_BIT])
    else $error("brown-out enable not written");
  a_pllfault_write: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_en_write(SCIEM_PLL_FAULT_BIT, 1'b0) |=> !state_q.enable[SCIEM_PLL_FAULT_BIT])
    else $error("pll fault enable not cleared");
  a_reset_clears: assert property (@(posedge sys_clk_in)
    srst_in |=> state_q.enable == 7'h00 && !irq_out)
    else $error("enables not zero after reset");
  a_read_upper_zero: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    wb_ack_out |-> wb_dat_out[31:7] == 25'h0000000)
    else $error("reserved read bits not zero");
  a_enable_stable: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !(req && wb_we_in && dec == SCIEM_SEL_EN) |=> $stable(state_q.enable))
    else $error("enable changed without write");
  a_irq_combine: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (masked != 7'h00) |=> irq_out)
    else $error("interrupt low with a masked flag set");
  a_irq_quiet: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (masked == 7'h00) |=> !irq_out)
    else $error("interrupt high with no masked flag");

  // The other enables gate their own flags alike; a lone flag keeps
  // the disabled case free of other flags that would raise the request
  for (genvar g = 0; g < SCIEM_NEV; g++)
  begin : g_gate
    a_bit_raises: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (state_q.enable[g] && ev.raw_event_status[g]) |=> irq_out)
      else $error("enabled event did not raise interrupt");
    a_bit_gated: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      (!state_q.enable[g] && ev.raw_event_status == (7'h01 << g)) |=> !irq_out)
      else $error("disabled event raised interrupt");
  end

  // Mask reads return the mask as it stood when the read was taken
  a_read_enable: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_read(SCIEM_SEL_EN) |=> wb_dat_out[6:0] == $past(state_q.enable))
    else $error("enable read data wrong");
  // A write with byte lane 0 off must leave the mask alone
  a_sel_ignored: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (req && wb_we_in && dec == SCIEM_SEL_EN && !wb_sel_in[0]) |=> $stable(state_q.enable))
    else $error("enable changed by write without lane 0");

  // Bus answers: one pulse each; a hole in the map answers with err
  a_ack_pulse: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_take_mapped |=> s_ack_pulse)
    else $error("mapped access not answered by one ack");
  a_err_unmapped: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_take_unmapped |=> s_err_pulse)
    else $error("unmapped access not answered by one err");
  // An errored access must neither touch the mask nor leak data
  a_unmapped_inert: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_take_unmapped |=> $stable(state_q.enable))
    else $error("unmapped access changed the mask");
  a_err_read_zero: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_take_unmapped |=> wb_dat_out == 32'h0000_0000)
    else $error("unmapped read returned data");

  // Raw flags: no direct software write; write-one on masked status clears
  a_raw_nowrite: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (req && wb_we_in && dec == SCIEM_SEL_RAW) |-> ev.clear_req == 7'h00)
    else $error("raw status write reached the flags");
  a_stat_clears: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_clear_bit(SCIEM_BROWNOUT_BIT) |=> !ev.raw_event_status[SCIEM_BROWNOUT_BIT])
    else $error("brown-out flag not cleared");
  a_pllfault_clears: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_clear_bit(SCIEM_PLL_FAULT_BIT) |=> !ev.raw_event_status[SCIEM_PLL_FAULT_BIT])
    else $error("pll fault flag not cleared");
  // An event that meets its clear must not be lost
  a_set_wins: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (req && wb_we_in && dec == SCIEM_SEL_STAT && wb_sel_in[0] && wb_dat_in[SCIEM_BROWNOUT_BIT]
      && ev.event_in[SCIEM_BROWNOUT_BIT]) |=> ev.raw_event_status[SCIEM_BROWNOUT_BIT])
    else $error("event lost against clear");
  // Status reads return the flags seen at the taking edge
  a_raw_read: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_read(SCIEM_SEL_RAW) |=> wb_dat_out[6:0] == $past(ev.raw_event_status))
    else $error("raw status read data wrong");
  a_stat_read: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    s_read(SCIEM_SEL_STAT) |=> wb_dat_out[6:0] == $past(masked))
    else $error("masked status read data wrong");

  // Reset leaves a quiet bus and no flags
  a_reset_quiet: assert property (@(posedge sys_clk_in)
    srst_in |=> !wb_ack_out && !wb_err_out && ev.raw_event_status == 7'h00)
    else $error("bus or flags not quiet after reset");

endmodule

// File: sciem_event_model.sv
// Stand-in for the analog monitors that feed the event inputs.
// Assumes the bench calls fire() from its main thread only.
`timescale 1ns/1ps
module sciem_event_model
  import sciem_pkg::*;
(
  input wire logic sys_clk_in,   // System clock
  output sciem_ev_t event_out    // Monitor outputs
);
  // ----------------------------------------
  // Pulse driver
  // ----------------------------------------
  initial event_out = '0;        // Monitors quiet at start
  // One-cycle pulse: the shortest event the core must catch
  task automatic fire(input sciem_ev_t bits);
    @(posedge sys_clk_in);
    event_out <= bits;
    @(posedge sys_clk_in);
    event_out <= '0;
  endtask
endmodule

// File: sciem_pkg.sv
// System-control event enable: shared constants and types.
// Assumes a 32-bit classic Wishbone slave port on a single 100 MHz clock.
package sciem_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SCIEM_RAW_OFFSET = 12'h050;    // Raw event status
  localparam logic [11:0] SCIEM_EN_OFFSET = 12'h054;     // Event enable mask
  localparam logic [11:0] SCIEM_STAT_OFFSET = 12'h058;   // Masked status, write one to clear

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int SCIEM_NEV = 7;                          // Number of event bits
  localparam int SCIEM_PLL_FAULT_BIT = 0;                // Pll fault
  localparam int SCIEM_BROWNOUT_BIT = 1;                 // Brown-out
  localparam int SCIEM_REGULATOR_BIT = 2;                // Regulator unregulated
  localparam int SCIEM_MAIN_OSC_BIT = 3;                 // Main oscillator fault
  localparam int SCIEM_INT_OSC_BIT = 4;                  // Internal oscillator fault
  localparam int SCIEM_CUR_LIMIT_BIT = 5;                // Current limit
  localparam int SCIEM_PLL_LOCK_BIT = 6;                 // Pll locked

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] SCIEM_EN_RESET = 7'h00;         // All enables off
  localparam logic [6:0] SCIEM_RAW_RESET = 7'h00;        // No events pending

  typedef logic [6:0] sciem_ev_t;                        // One bit per event

endpackage

// File: sciem_raw_flags.sv
// Raw event flags: set by hardware events, cleared only by masked-status clear.
// Assumes event inputs are already synchronous to sys_clk_in.
`timescale 1ns/1ps
module sciem_raw_flags
  import sciem_pkg::*;
(
  input wire logic sys_clk_in,        // System clock
  input wire logic srst_in,           // Synchronous reset, active high
  sciem_ev_if.core ev                 // Event bundle
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    sciem_ev_t raw;                   // Sticky raw flags
  } sciem_raw_state_t;

  sciem_raw_state_t state_q;          // Registered state
  sciem_raw_state_t state_d;          // Next state

  // Set wins over clear so a coincident event is not lost
  always_comb
  begin
    state_d = state_q;
    state_d.raw = (state_q.raw & ~ev.clear_req) | ev.event_in;
  end

  // Register the state
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_q.raw <= SCIEM_RAW_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign ev.raw_event_status = state_q.raw;
  // Request is any set bit of flags AND enables
  assign ev.irq = |(state_q.raw & ev.sysctl_event_enable);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_event_sets_flag: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ev.event_in[SCIEM_BROWNOUT_BIT] |=> state_q.raw[SCIEM_BROWNOUT_BIT])
    else $error("brown-out event did not set raw flag");
  a_flag_holds: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (state_q.raw[SCIEM_PLL_FAULT_BIT] && !ev.clear_req[SCIEM_PLL_FAULT_BIT])
      |=> state_q.raw[SCIEM_PLL_FAULT_BIT])
    else $error("raw flag dropped without clear");
  a_flag_no_self: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!state_q.raw[SCIEM_CUR_LIMIT_BIT] && !ev.event_in[SCIEM_CUR_LIMIT_BIT])
      |=> !state_q.raw[SCIEM_CUR_LIMIT_BIT])
    else $error("raw flag set without event");

endmodule

// File: tb_top.sv
// Self-checking bench for the event enable block.
// Assumes ack one cycle after a taken request and registered irq.
`timescale 1ns/1ps
module tb_top
  import sciem_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk_in = 1'b0;       // 100 MHz clock
  logic srst_in = 1'b1;          // Reset held at start
  sciem_ev_t event_in;           // From the monitor model
  logic wb_cyc_in = 1'b0;        // Bus cycle
  logic wb_stb_in = 1'b0;        // Bus strobe
  logic wb_we_in = 1'b0;         // Bus direction
  logic [11:0] wb_adr_in = 12'h000;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out;       // Read data
  logic wb_ack_out;              // Acknowledge
  logic wb_err_out;              // Error answer
  logic irq_out;                 // Interrupt level
  int err_total = 0;             // Mismatches
  int num_checks = 0;            // Comparisons
  always #5 sys_clk_in = ~sys_clk_in;
  sciem_event_enable u_sciem_event_enable (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .event_in(event_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out), .irq_out(irq_out));
  sciem_event_model u_sciem_event_model (.sys_clk_in(sys_clk_in), .event_out(event_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Classic single cycle; ack or err sampled at a rising edge, only the watchdog ends a hang
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel, output logic [31:0] rd, output logic er);
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    wb_sel_in <= sel;
    do
    begin
      @(posedge sys_clk_in);
    end
    while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1);
    // Answer taken at the edge that shows it; release right after
    rd = wb_dat_out;
    er = wb_err_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] adr, input logic [31:0] dat, input logic [3:0] sel = 4'hF);
    logic [31:0] rd;
    logic er;
    bus(1'b1, adr, dat, sel, rd, er);
  endtask
  task automatic rdchk(input string name, input logic [11:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    bus(1'b0, adr, 32'h0, 4'hF, rd, er);
    chk(name, rd, exp);
    chk({name, "_err"}, {31'h0, er}, 32'h0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset state and read/write behaviour of the mask
  task automatic t_access();
    rdchk("enable_reset", SCIEM_EN_OFFSET, 32'h0);
    chk("irq_reset", {31'h0, irq_out}, 32'h0);
    wr(SCIEM_EN_OFFSET, 32'hFFFFFFFF);
    rdchk("enable_all", SCIEM_EN_OFFSET, 32'h7F);
    wr(SCIEM_EN_OFFSET, 32'h2);
    rdchk("enable_bit1", SCIEM_EN_OFFSET, 32'h2);
    wr(SCIEM_EN_OFFSET, 32'h1);
    rdchk("enable_bit0", SCIEM_EN_OFFSET, 32'h1);
    wr(SCIEM_EN_OFFSET, 32'h0);
  endtask
  // Refused accesses: raw flag write, unselected byte write, unmapped read
  task automatic t_refuse();
    logic [31:0] rd;
    logic er;
    wr(SCIEM_RAW_OFFSET, 32'h7F);
    rdchk("raw_locked", SCIEM_RAW_OFFSET, 32'h0);
    wr(SCIEM_EN_OFFSET, 32'h7F, 4'hE);
    rdchk("enable_nosel", SCIEM_EN_OFFSET, 32'h0);
    bus(1'b0, 12'h100, 32'h0, 4'hF, rd, er);
    chk("unmapped_err", {31'h0, er}, 32'h1);
  endtask
  // Each event first masked, then enabled, then cleared
  task automatic t_mask();
    sciem_ev_t m;
    for (int i = 0; i < SCIEM_NEV; i++)
    begin
      m = 7'h01 << i;
      wr(SCIEM_EN_OFFSET, {25'h0, ~m});
      u_sciem_event_model.fire(m);
      repeat (6) @(posedge sys_clk_in);
      chk("irq_masked", {31'h0, irq_out}, 32'h0);
      rdchk("raw_set", SCIEM_RAW_OFFSET, {25'h0, m});
      rdchk("masked_none", SCIEM_STAT_OFFSET, 32'h0);
      wr(SCIEM_EN_OFFSET, {25'h0, m});
      repeat (2) @(posedge sys_clk_in);
      chk("irq_enabled", {31'h0, irq_out}, 32'h1);
      rdchk("masked_one", SCIEM_STAT_OFFSET, {25'h0, m});
      wr(SCIEM_STAT_OFFSET, {25'h0, m});
      repeat (2) @(posedge sys_clk_in);
      chk("irq_cleared", {31'h0, irq_out}, 32'h0);
      rdchk("raw_cleared", SCIEM_RAW_OFFSET, 32'h0);
    end
    wr(SCIEM_EN_OFFSET, 32'h0);
  endtask
  // Mid-run reset: mask, flags and request all return to zero
  task automatic t_reset();
    wr(SCIEM_EN_OFFSET, 32'h7F);
    u_sciem_event_model.fire(7'h7F);
    repeat (6) @(posedge sys_clk_in);
    chk("irq_before_reset", {31'h0, irq_out}, 32'h1);
    srst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in);
    chk("irq_after_reset", {31'h0, irq_out}, 32'h0);
    rdchk("enable_after_reset", SCIEM_EN_OFFSET, 32'h0);
    rdchk("raw_after_reset", SCIEM_RAW_OFFSET, 32'h0);
  endtask
  // ----------------------------------------
  // Closing and main sequence
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog: the whole run needs well under 20000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    err_total++;
    finish_test();
  end
  initial
  begin
    repeat (10) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    t_access();
    t_refuse();
    t_mask();
    t_reset();
    finish_test();
  end
endmodule
